/* lpms_pkg.sv */
package lpms_pkg;

    // bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int IRQ_N  = 7;
    localparam int PC_W   = 14;

    // register indices, byte address is four times the index
    localparam logic [7:0] RAMF_IDX = 8'h21;
    localparam logic [7:0] STAT_IDX = 8'h22;
    localparam logic [7:0] CTRL_IDX = 8'h23;

    // field positions
    localparam int RAMF_BIT      = 3;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_WAKE_LSB = 2;
    localparam int STAT_NOP_BIT  = 4;

    // program restart vector
    localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_SETTLE_NS = 2000;
    localparam int SETTLE_CYC_I  =
        (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_CYC =
        (SETTLE_CYC_I < 1) ? 8'h01 : 8'(SETTLE_CYC_I);

    // values after reset
    localparam logic [7:0] CTRL_RESET = SETTLE_CYC;

    typedef enum logic [1:0] {
        LPMS_ACTIVE  = 2'b00,
        LPMS_STANDBY = 2'b01,
        LPMS_STOP    = 2'b10
    } lpms_mode_t;

    typedef enum logic [1:0] {
        LPMS_WAKE_RESET = 2'b00,
        LPMS_WAKE_IRQ   = 2'b01,
        LPMS_WAKE_PIN   = 2'b10
    } lpms_wake_t;

    typedef struct packed {
        lpms_mode_t  mode;
        logic        ram_valid;
        logic [7:0]  settle_cycles;
        lpms_wake_t  wake_cause;
        logic        nop_seen;
        logic [7:0]  rdata;
        logic        resume;
        logic        service;
        logic        nop;
        logic        restart;
        logic        boot;
    } lpms_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic       done;
    } lpms_timer_t;

endpackage

/* lpms_settle_timer.sv */
`timescale 1ns/1ps
module lpms_settle_timer
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // hold detection
    input  wire logic       arm,
    input  wire logic       level,
    input  wire logic [7:0] threshold,
    output logic            done
);
    import lpms_pkg::*;

    lpms_timer_t st;
    lpms_timer_t next_st;
    logic [7:0]  thr;

    // a zero threshold would let a glitch wake the part
    assign thr = (threshold == 8'h00) ? 8'h01 : threshold;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (arm && level) begin
            if (st.count != 8'hff) begin
                next_st.count = st.count + 8'h01;
            end
            next_st.done = ((st.count + 8'h01) >= thr);
        end else begin
            next_st.count = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;
endmodule

/* lpms_sequencer.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module lpms_sequencer
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // instruction decoder
    input  wire logic                     stop_op,
    input  wire logic                     enter_idle_op,
    // interrupt logic
    input  wire logic                     global_irq_enable,
    input  wire logic [lpms_pkg::IRQ_N-1:0] irq_flags,
    input  wire logic [lpms_pkg::IRQ_N-1:0] irq_masks,
    // external pin, active low
    input  wire logic                     stop_wake_pin_n,
    // register port
    input  wire logic [lpms_pkg::ADDR_W-1:0] addr,
    input  wire logic [lpms_pkg::DATA_W-1:0] wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic [lpms_pkg::DATA_W-1:0]   rdata,
    // clock gating
    output logic                          osc_run,
    output logic                          cpu_clk_en,
    output logic                          periph_clk_en,
    // reset holds
    output logic                          cpu_rst,
    output logic                          periph_rst,
    output logic                          io_rst,
    output logic                          io_out_allow,
    // cpu sequencing
    output logic                          resume,
    output logic                          irq_service,
    output logic                          op_nop,
    output logic                          fetch_restart,
    output logic [lpms_pkg::PC_W-1:0]     fetch_addr,
    output lpms_pkg::lpms_mode_t          mode
);
    import lpms_pkg::*;

    lpms_state_t st;
    lpms_state_t next_st;
    logic        pin_hold_met;
    logic        pending;
    logic        blocked;
    logic        hit_ramf;
    logic        hit_stat;
    logic        hit_ctrl;

    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        idx
    );
        addr_hit = (a == {idx, 2'b00});
    endfunction

    function automatic logic unmasked_any(
        input logic [IRQ_N-1:0] flags,
        input logic [IRQ_N-1:0] masks
    );
        unmasked_any = |(flags & ~masks);
    endfunction

    assign pending  = unmasked_any(irq_flags, irq_masks);
    assign blocked  = !global_irq_enable && pending;
    assign hit_ramf = addr_hit(addr, RAMF_IDX);
    assign hit_stat = addr_hit(addr, STAT_IDX);
    assign hit_ctrl = addr_hit(addr, CTRL_IDX);

    // the counter only runs in stop, so the pin is dead elsewhere
    lpms_settle_timer u_settle (
        .clk       (clk),
        .rstn      (rstn),
        .arm       (st.mode == LPMS_STOP),
        .level     (!stop_wake_pin_n),
        .threshold (st.settle_cycles),
        .done      (pin_hold_met)
    );

    always_comb begin
        next_st = st;
        next_st.resume  = 1'b0;
        next_st.service = 1'b0;
        next_st.nop     = 1'b0;
        next_st.restart = 1'b0;
        next_st.boot    = 1'b0;
        next_st.rdata   = 8'h00;

        // software writes first so hardware events win below
        if (wr) begin
            if (hit_ramf) begin
                next_st.ram_valid = wdata[RAMF_BIT];
            end else if (hit_stat) begin
                if (wdata[STAT_NOP_BIT]) begin
                    next_st.nop_seen = 1'b0;
                end
            end else if (hit_ctrl) begin
                next_st.settle_cycles = wdata;
            end
        end

        // first cycle after reset restarts the program
        if (st.boot) begin
            next_st.restart = 1'b1;
        end

        case (st.mode)
            LPMS_ACTIVE: begin
                if (stop_op || enter_idle_op) begin
                    if (blocked) begin
                        next_st.nop      = 1'b1;
                        next_st.nop_seen = 1'b1;
                    end else if (stop_op) begin
                        next_st.mode = LPMS_STOP;
                    end else begin
                        next_st.mode = LPMS_STANDBY;
                    end
                end
            end
            LPMS_STANDBY: begin
                // any unmasked request wakes, enabled or not
                if (pending) begin
                    next_st.mode       = LPMS_ACTIVE;
                    next_st.resume     = 1'b1;
                    next_st.service    = global_irq_enable;
                    next_st.wake_cause = LPMS_WAKE_IRQ;
                end
            end
            LPMS_STOP: begin
                if (pin_hold_met) begin
                    next_st.mode       = LPMS_ACTIVE;
                    next_st.restart    = 1'b1;
                    next_st.ram_valid  = 1'b1;
                    next_st.wake_cause = LPMS_WAKE_PIN;
                end
            end
            default: begin
                next_st.mode = LPMS_ACTIVE;
            end
        endcase

        if (rd) begin
            if (hit_ramf) begin
                next_st.rdata[RAMF_BIT] = st.ram_valid;
            end else if (hit_stat) begin
                next_st.rdata[STAT_MODE_LSB +: 2] = st.mode;
                next_st.rdata[STAT_WAKE_LSB +: 2] = st.wake_cause;
                next_st.rdata[STAT_NOP_BIT]       = st.nop_seen;
            end else if (hit_ctrl) begin
                next_st.rdata = st.settle_cycles;
            end
        end
    end

    // reset clears the flag, so a reset exit reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st               <= '0;
            st.mode          <= LPMS_ACTIVE;
            st.wake_cause    <= LPMS_WAKE_RESET;
            st.ram_valid     <= 1'b0;
            st.settle_cycles <= CTRL_RESET;
            st.boot          <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // decoded from the current mode only
    assign mode          = st.mode;
    assign osc_run       = (st.mode != LPMS_STOP);
    assign cpu_clk_en    = (st.mode == LPMS_ACTIVE);
    assign periph_clk_en = (st.mode != LPMS_STOP);
    // cpu registers are not restored; ram sits outside this reset
    assign cpu_rst       = (st.mode == LPMS_STOP);
    assign periph_rst    = (st.mode == LPMS_STOP);
    assign io_rst        = (st.mode == LPMS_STOP);
    assign io_out_allow  = (st.mode != LPMS_STOP);

    assign rdata         = st.rdata;
    assign resume        = st.resume;
    assign irq_service   = st.service;
    assign op_nop        = st.nop;
    assign fetch_restart = st.restart;
    assign fetch_addr    = RESET_VECTOR;
endmodule

/* lpms_wake_drv.sv */
`timescale 1ns/1ps
module lpms_wake_drv (
    // clock
    input  wire logic       clk,
    // command from bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    // wake pin, pulled up when released
    output logic            stop_wake_pin_n
);
    logic [7:0] cnt = 8'h00;
    // low for exactly len edges, so the bench can hold short or long
    always_ff @(posedge clk) begin
        if (go) begin
            cnt <= len;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    assign stop_wake_pin_n = (cnt == 8'h00);
endmodule

/* lpms_sequencer_asserts.sv */
`timescale 1ns/1ps
module lpms_sequencer_asserts
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // requests
    input  wire logic                       stop_op,
    input  wire logic                       enter_idle_op,
    input  wire logic                       global_irq_enable,
    input  wire logic [lpms_pkg::IRQ_N-1:0] irq_flags,
    input  wire logic [lpms_pkg::IRQ_N-1:0] irq_masks,
    input  wire logic                       stop_wake_pin_n,
    // answers
    input  wire logic                       osc_run,
    input  wire logic                       cpu_clk_en,
    input  wire logic                       periph_clk_en,
    input  wire logic                       cpu_rst,
    input  wire logic                       io_out_allow,
    input  wire logic                       resume,
    input  wire logic                       irq_service,
    input  wire logic                       op_nop,
    input  wire logic                       fetch_restart,
    input  wire logic [lpms_pkg::PC_W-1:0]  fetch_addr,
    input  wire lpms_pkg::lpms_mode_t       mode
);
    logic pend;
    logic blk;
    logic act;
    assign pend = |(irq_flags & ~irq_masks);
    assign blk  = pend && !global_irq_enable;
    assign act  = (mode == LPMS_ACTIVE);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_idle_entry: assert property (
        act && enter_idle_op && !stop_op && !blk |=> mode == LPMS_STANDBY)
        else $error("idle entry");
    chk_stop_entry: assert property (
        act && stop_op && !blk |=> mode == LPMS_STOP)
        else $error("stop entry");
    chk_nop_cancel: assert property (
        act && (stop_op || enter_idle_op) && blk |=> op_nop && act)
        else $error("nop cancel");
    chk_standby_gate: assert property (
        mode == LPMS_STANDBY |-> !cpu_clk_en && osc_run && periph_clk_en)
        else $error("gate");
    chk_stop_outs: assert property (
        mode == LPMS_STOP |-> !osc_run && cpu_rst && !io_out_allow)
        else $error("stop");
    chk_pin_ignored: assert property (
        !stop_wake_pin_n && mode != LPMS_STOP && $past(rstn)
        |=> !fetch_restart)
        else $error("pin");
    chk_wake_vector: assert property (
        fetch_restart |-> fetch_addr == RESET_VECTOR && act)
        else $error("vector");
    chk_irq_wake: assert property (
        mode == LPMS_STANDBY && pend
        |=> act && resume && irq_service == $past(global_irq_enable))
        else $error("irq wake");
    cover property (mode == LPMS_STANDBY ##1 resume);
    cover property (op_nop);
    cover property (mode == LPMS_STOP ##1 fetch_restart);
endmodule
bind lpms_sequencer lpms_sequencer_asserts u_lpms_sequencer_asserts (.*);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import lpms_pkg::*;
    logic              clk, rstn, stop_op, enter_idle_op, wr, rd, go;
    logic              global_irq_enable, stop_wake_pin_n, osc_run;
    logic              cpu_clk_en, periph_clk_en, cpu_rst, periph_rst;
    logic              io_rst, io_out_allow, resume, irq_service;
    logic              op_nop, fetch_restart;
    logic [IRQ_N-1:0]  irq_flags, irq_masks;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata, rdata, len;
    logic [PC_W-1:0]   fetch_addr;
    lpms_mode_t        mode;
    int                n_fail, checks_done;
    lpms_sequencer u_lpms_sequencer (
        .clk, .rstn, .stop_op, .enter_idle_op, .global_irq_enable,
        .irq_flags, .irq_masks, .stop_wake_pin_n, .addr, .wdata, .wr, .rd,
        .rdata, .osc_run, .cpu_clk_en, .periph_clk_en, .cpu_rst,
        .periph_rst, .io_rst, .io_out_allow, .resume, .irq_service,
        .op_nop, .fetch_restart, .fetch_addr, .mode
    );
    lpms_wake_drv u_lpms_wake_drv (.clk, .go, .len, .stop_wake_pin_n);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task tick;
        @(posedge clk);
        #1;
    endtask
    task results;
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr_reg(input logic [9:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick;
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [9:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        tick;
        rd <= 1'b0;
        chk(rdata, e);
        tick;
    endtask
    // only the strobe that was raised is lowered, so calls can follow
    task op(input logic s);
        if (s) begin
            stop_op <= 1'b1;
        end else begin
            enter_idle_op <= 1'b1;
        end
        tick;
        if (s) begin
            stop_op <= 1'b0;
        end else begin
            enter_idle_op <= 1'b0;
        end
    endtask
    task hold(input logic [7:0] n);
        len <= n;
        go <= 1'b1;
        tick;
        go <= 1'b0;
    endtask
    task t_regs;
        rd_chk(10'h088, 8'h00);
        rd_chk(10'h08c, 8'h14);
        wr_reg(10'h090, 8'hff);
        rd_chk(10'h090, 8'h00);
        wr_reg(10'h084, 8'h08);
        rd_chk(10'h084, 8'h08);
        wr_reg(10'h084, 8'h00);
    endtask
    task t_idle(input logic en);
        global_irq_enable <= en;
        irq_flags <= 7'h00;
        op(1'b0);
        chk({mode, cpu_clk_en, osc_run, periph_clk_en, io_out_allow},
            8'h17);
        op(1'b1);
        hold(8'h04);
        repeat (5) tick;
        chk(mode, LPMS_STANDBY);
        irq_flags <= 7'h40;
        tick;
        chk({mode, resume, irq_service}, {6'h00, 1'b1, en});
        irq_flags <= 7'h00;
        tick;
    endtask
    task t_nop;
        global_irq_enable <= 1'b0;
        irq_flags <= 7'h02;
        op(1'b1);
        chk({mode, op_nop}, 8'h01);
        rd_chk(10'h088, 8'h14);
        wr_reg(10'h088, 8'h10);
        rd_chk(10'h088, 8'h04);
        irq_masks <= 7'h02;
        op(1'b0);
        chk(mode, LPMS_STANDBY);
        irq_masks <= 7'h00;
        tick;
        chk({mode, resume, irq_service}, 8'h02);
        irq_flags <= 7'h00;
    endtask
    task t_pin;
        int i;
        wr_reg(10'h08c, 8'h03);
        op(1'b1);
        chk({mode, osc_run, cpu_clk_en, periph_clk_en, cpu_rst, periph_rst,
            io_rst, io_out_allow}, 16'h010e);
        hold(8'h02);
        repeat (4) tick;
        chk(mode, LPMS_STOP);
        hold(8'h03);
        for (i = 0; i < 20 && fetch_restart !== 1'b1; i++) begin
            tick;
        end
        if (fetch_restart !== 1'b1) begin
            chk(fetch_restart, 16'h0001);
            results;
        end
        chk(mode, LPMS_ACTIVE);
        chk(fetch_addr, RESET_VECTOR);
        rd_chk(10'h084, 8'h08);
        rd_chk(10'h088, 8'h08);
    endtask
    task t_rst;
        // both opcodes at once: stop has priority
        stop_op <= 1'b1;
        enter_idle_op <= 1'b1;
        tick;
        stop_op <= 1'b0;
        enter_idle_op <= 1'b0;
        chk(mode, LPMS_STOP);
        rstn <= 1'b0;
        tick;
        chk({mode, osc_run, cpu_rst}, 8'h02);
        rstn <= 1'b1;
        tick;
        chk(fetch_restart, 8'h01);
        rd_chk(10'h084, 8'h00);
        rd_chk(10'h08c, 8'h14);
    endtask
    initial begin
        {rstn, stop_op, enter_idle_op, wr, rd, go, global_irq_enable} = 7'h00;
        {irq_flags, irq_masks, addr, wdata, len} = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        #1;
        rstn <= 1'b1;
        tick;
        chk(fetch_restart, 8'h01);
        t_regs;
        t_idle(1'b0);
        t_idle(1'b1);
        t_nop;
        t_pin;
        t_rst;
        results;
    end
endmodule
